// file: verilog/wid_pkg.sv
/*
 * Constants for the wake-up and interrupt dispatch block.
 * Assumes nothing of its surroundings; imported by the block's module header.
 */
package wid_pkg;

    // ------------------------------------------------------------
    // Source indices and count
    // ------------------------------------------------------------
    localparam int WID_NSRC = 4;
    localparam int WID_SRC_EXT = 0;
    localparam int WID_SRC_PORT = 1;
    localparam int WID_SRC_TMR = 2;
    localparam int WID_SRC_SPI = 3;

    // ------------------------------------------------------------
    // Operating modes and vectors
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WID_MODE_SLEEP,
        WID_MODE_IDLE,
        WID_MODE_GREEN,
        WID_MODE_NORMAL
    } wid_mode_t;

    localparam logic [7:0] WID_PORT_VECTOR = 8'h06;
    localparam logic [7:0] WID_VEC_RESET = 8'h00;

endpackage : wid_pkg

// file: verilog/wid_dispatch.sv
/*
 * Wake-up and interrupt dispatch for four event sources.
 * Assumes events and the core sequencer run on clk_i; source flags are
 * single-cycle pulses from on-chip logic, software clears pending flags.
 */
// Functional notes
// [R1] Sleep or idle: enabled-wake event wakes; without global or source irq enable, resume next.
// [R2] Sleep or idle with global, wake and irq enables: wake and branch; timer idle only.
// [R3] Serial peripheral wakes the core only while operating as slave.
// [R4] Irq enable zero gives no branch awake; wake enable zero gives no wake asleep.
// [R5] Green or normal: irq-enabled event branches if global enabled, else continues.
// [R6] Global disabled before sleep: resume at instruction after the sleep instruction.
// [R7] Port change interrupt taken transfers execution to vector 006H.
// [R8] Software disables the watchdog before sleeping on a non-reset wake source.
// [R9] Each source event latches as pending until software clears it.
`timescale 1ns/10ps
`default_nettype none

module wid_dispatch
    import wid_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Event sources, one-cycle pulses; the serial slave status is a level
    input wire logic ext_pin_evt_i,
    input wire logic port_change_evt_i,
    input wire logic main_timer_ovf_i,
    input wire logic serial_periph_rx_i,
    input wire logic serial_periph_slave_i,
    // Enables
    input wire logic ext_pin_wake_en_i,
    input wire logic ext_pin_irq_en_i,
    input wire logic port_change_wake_en_i,
    input wire logic port_change_irq_en_i,
    input wire logic timer_overflow_irq_en_i,
    input wire logic serial_periph_wake_en_i,
    input wire logic serial_periph_irq_en_i,
    // Core state
    input wire logic global_irq_en_i,
    input wire wid_mode_t mode_i,
    input wire logic [WID_NSRC-1:0] pend_clr_i,
    // Decisions to the core sequencer
    output logic [WID_NSRC-1:0] pending_o,
    output logic wake_o,
    output logic branch_o,
    output logic resume_next_o,
    output logic [7:0] vector_o
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The event and enable vectors below are packed for exactly these four source slots.
    if (WID_NSRC != 4) begin : g_nsrc_check
        $error("source count must be four");
    end
    if (WID_SRC_EXT != 0 || WID_SRC_PORT != 1 || WID_SRC_TMR != 2 || WID_SRC_SPI != 3) begin : g_slot_check
        $error("source slots must follow the packing order");
    end

    // ------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------
    logic [WID_NSRC-1:0] evt;
    logic [WID_NSRC-1:0] wake_en;
    logic [WID_NSRC-1:0] irq_en;
    logic [WID_NSRC-1:0] pend_reg;
    logic [WID_NSRC-1:0] wake_req;
    logic [WID_NSRC-1:0] irq_req;
    logic asleep;
    logic [7:0] vec_next;
    logic wake_irq_hit;
    logic wake_next;
    logic branch_next;
    logic resume_next;

    assign evt = {serial_periph_rx_i, main_timer_ovf_i, port_change_evt_i, ext_pin_evt_i};
    // The timer has no wake enable; in idle its irq enable alone wakes the core.
    assign wake_en = {serial_periph_wake_en_i & serial_periph_slave_i, // [R3]
                      (mode_i == WID_MODE_IDLE) & timer_overflow_irq_en_i, // [R2]
                      port_change_wake_en_i, ext_pin_wake_en_i};
    assign irq_en = {serial_periph_irq_en_i, timer_overflow_irq_en_i,
                     port_change_irq_en_i, ext_pin_irq_en_i};
    assign asleep = (mode_i == WID_MODE_SLEEP) || (mode_i == WID_MODE_IDLE);

    // Set beats clear so an event arriving during the clear is kept.
    genvar g;
    generate
        for (g = 0; g < WID_NSRC; g++) begin : g_pend
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    pend_reg[g] <= 1'b0;
                end else if (evt[g]) begin
                    pend_reg[g] <= 1'b1; // [R9]
                end else if (pend_clr_i[g]) begin
                    pend_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign wake_req = pend_reg & wake_en; // [R4]
    assign irq_req = pend_reg & irq_en; // [R4]

    // ------------------------------------------------------------
    // Decision
    // ------------------------------------------------------------
    // Lowest source index wins the vector when several are pending.
    // The vector is offered even when no branch follows; the sequencer uses it only on a branch.
    always_comb begin
        vec_next = WID_VEC_RESET;
        for (int i = WID_NSRC - 1; i >= 0; i--) begin
            if (irq_req[i]) begin
                vec_next = (i == WID_SRC_PORT) ? WID_PORT_VECTOR : 8'(i + 1); // [R7]
            end
        end
    end

    // A sleeping core branches only for a source that both woke it and may interrupt.
    assign wake_irq_hit = |(wake_req & irq_en);

    always_comb begin
        wake_next = 1'b0;
        branch_next = 1'b0;
        resume_next = 1'b0;
        if (asleep) begin
            wake_next = |wake_req; // [R1]
            branch_next = global_irq_en_i && wake_irq_hit; // [R2]
            resume_next = |wake_req && !(global_irq_en_i && wake_irq_hit); // [R1] [R6]
        end else begin
            branch_next = global_irq_en_i && |irq_req; // [R5]
            resume_next = !global_irq_en_i && |irq_req; // [R5]
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= wake_next;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            branch_o <= 1'b0;
        end else begin
            branch_o <= branch_next;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            resume_next_o <= 1'b0;
        end else begin
            resume_next_o <= resume_next;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vector_o <= WID_VEC_RESET;
        end else begin
            vector_o <= vec_next;
        end
    end

    // The copy runs one cycle behind the internal flags, in step with the decisions.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pending_o <= '0;
        end else begin
            pending_o <= pend_reg;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_sleep_tmr_evt;
        (mode_i == WID_MODE_SLEEP) && main_timer_ovf_i && timer_overflow_irq_en_i && pend_reg == 4'h0;
    endsequence

    sequence s_sleep_tmr_alone;
        (mode_i == WID_MODE_SLEEP) && timer_overflow_irq_en_i && pend_reg == 4'h4;
    endsequence

    sequence s_idle_port_evt;
        (mode_i == WID_MODE_IDLE) && port_change_evt_i && pend_reg == 4'h0;
    endsequence

    sequence s_idle_port_armed;
        (mode_i == WID_MODE_IDLE) && global_irq_en_i && port_change_wake_en_i && port_change_irq_en_i
            && pend_reg == 4'h2;
    endsequence

    AST_PEND_SET: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R9]
        ext_pin_evt_i |=> pend_reg[WID_SRC_EXT])
        else $error("event not latched");
    AST_PEND_CLEAR: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R9]
        pend_clr_i[WID_SRC_EXT] && !ext_pin_evt_i |=> !pend_reg[WID_SRC_EXT])
        else $error("pending flag not cleared");
    AST_TMR_NO_SLEEP_WAKE: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R2]
        s_sleep_tmr_evt ##1 s_sleep_tmr_alone |=> !wake_o)
        else $error("timer woke from sleep");
    AST_SPI_MASTER: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R3]
        asleep && !serial_periph_slave_i && wake_req == 4'h0 |=> !wake_o)
        else $error("wake without slave spi");
    AST_SPI_MASTER_EVT: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R3]
        asleep && !serial_periph_slave_i && pend_reg == 4'h8 |=> !wake_o)
        else $error("master spi event woke the core");
    AST_WAKE_CAUSE: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R1]
        asleep && |wake_req |=> wake_o)
        else $error("missed wake");
    AST_NO_WAKE: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R4]
        wake_req == 4'h0 |=> !wake_o)
        else $error("wake without enable");
    AST_AWAKE_NO_WAKE: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R4]
        !asleep |=> !wake_o)
        else $error("wake while running");
    AST_AWAKE_BRANCH: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R5]
        !asleep && global_irq_en_i && |irq_req |=> branch_o && !resume_next_o)
        else $error("no branch");
    AST_GLOBAL_OFF_NO_BRANCH: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R6]
        !global_irq_en_i |=> !branch_o)
        else $error("branch with global off");
    AST_SLEEP_RESUME_NEXT: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R6]
        asleep && !global_irq_en_i && |wake_req |=> resume_next_o && !branch_o)
        else $error("no resume after wake with global off");
    AST_PORT_VEC: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R7]
        irq_req == 4'h2 |=> vector_o == WID_PORT_VECTOR)
        else $error("bad port vector");
    AST_PORT_IDLE_BRANCH: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R7]
        s_idle_port_evt ##1 s_idle_port_armed |=> wake_o && branch_o && vector_o == WID_PORT_VECTOR)
        else $error("port wake did not branch to its vector");
    AST_NO_IRQ: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R4]
        irq_req == 4'h0 && !asleep |=> !branch_o && !resume_next_o)
        else $error("spurious irq");

endmodule : wid_dispatch

`default_nettype wire

// file: tb/wid_src_model.sv
/* Event source model: turns a fire request into one-cycle event pulses.
   Assumes the bench raises fire_i just after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module wid_src_model (
    input wire logic clk_i,
    input wire logic [3:0] fire_i,
    output logic [3:0] evt_o
);
    // Each source repeats fire_i one cycle later, for as long as it is held; the bench holds it one cycle, as the on-chip logic pulses.
    always_ff @(posedge clk_i) begin
        evt_o <= fire_i;
    end
endmodule : wid_src_model
`default_nettype wire

// file: tb/tb_top.sv
/* Bench for the dispatch block: sweeps mode, source and enables.
   Assumes decisions settle two edges after an event and drop after a clear. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import wid_pkg::*;
    logic clk_i = 0, rstn_i = 0, we = 0, ie = 0, glob = 0, slv = 0, wake, br, nxt;
    logic [3:0] fire = 4'h0, clr = 4'h0, evt, pend;
    logic [7:0] vec;
    wid_mode_t mode = WID_MODE_NORMAL;
    int failures = 0, num_checks = 0, cyc = 0;
    always #4 clk_i = ~clk_i;
    wid_src_model u_src (.clk_i(clk_i), .fire_i(fire), .evt_o(evt));
    wid_dispatch u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ext_pin_evt_i(evt[0]), .port_change_evt_i(evt[1]),
        .main_timer_ovf_i(evt[2]), .serial_periph_rx_i(evt[3]), .serial_periph_slave_i(slv),
        .ext_pin_wake_en_i(we), .ext_pin_irq_en_i(ie), .port_change_wake_en_i(we), .port_change_irq_en_i(ie),
        .timer_overflow_irq_en_i(ie), .serial_periph_wake_en_i(we), .serial_periph_irq_en_i(ie),
        .global_irq_en_i(glob), .mode_i(mode), .pend_clr_i(clr), .pending_o(pend), .wake_o(wake),
        .branch_o(br), .resume_next_o(nxt), .vector_o(vec));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    // Fires the sources in m, checks the standing decision, then clears it.
    task automatic shot(input logic [3:0] m, input logic ew, input logic eb, input logic en, input logic [7:0] ev);
        fire = m;
        tick(1);
        fire = 4'h0;
        tick(3);
        chk(8'(pend), 8'(m));
        chk(8'(wake), 8'(ew));
        chk(8'(br), 8'(eb));
        chk(8'(nxt), 8'(en));
        chk(vec, ev);
        clr = m;
        tick(1);
        clr = 4'h0;
        tick(3);
        chk(8'({pend, wake, br, nxt}), 8'h00);
    endtask : shot
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end
    initial begin
        logic asl, w, b, n;
        tick(10);
        rstn_i = 1;
        tick(1);
        for (int md = 0; md < 4; md++) begin
            mode = wid_mode_t'(md); // The watchdog is taken as off before each sleep.
            for (int s = 0; s < 4; s++) begin
                for (int k = 0; k < 16; k++) begin
                    {slv, glob, ie, we} = 4'(k);
                    asl = md < 2;
                    // The timer wakes from idle only, on its interrupt enable alone.
                    w = asl && (s == 2 ? (md == 1 && ie) : (we && (s != 3 || slv)));
                    b = asl ? (w && glob && ie) : (ie && glob);
                    n = asl ? (w && !b) : (ie && !glob);
                    // The vector names the lowest irq-enabled pending source, taken or not.
                    shot(4'(1 << s), w, b, n, ie ? (s == 1 ? WID_PORT_VECTOR : 8'(s + 1)) : WID_VEC_RESET);
                end
            end
            $display("mode %0d sweep done", md);
        end
        mode = WID_MODE_NORMAL;
        {slv, glob, ie, we} = 4'hF;
        shot(4'h6, 1'b0, 1'b1, 1'b0, WID_PORT_VECTOR);
        $display("priority test done");
        // An event and its clear in the same cycle: the event must survive.
        fire = 4'h1;
        clr = 4'h1;
        tick(1);
        fire = 4'h0;
        tick(1);
        clr = 4'h0;
        tick(3);
        chk(8'(pend), 8'h01);
        clr = 4'h1;
        tick(1);
        clr = 4'h0;
        tick(3);
        chk(8'(pend), 8'h00);
        $display("set over clear test done");
        results();
    end
endmodule : tb_top
`default_nettype wire
